// [hw/acd_top.sv]
`timescale 1ns/1ps
`include "acd_cfg.svh"

module acd_top #(
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PCM clock
  output logic pcm_clk,
  output logic pcm_tick,
  // PDM clock
  output logic pdm_clk,
  output logic pdm_tick,
  output logic pdm_clk_oe,
  output logic pdm_master_select,
  // Rate converter clock
  output logic src_clk,
  output logic src_tick
);
  import acd_pkg::*;

  // ==========================================================
  // Addresses
  localparam logic [AW-1:0] ADDR_PCM_DIV = AW'(`ACD_IDX_PCM_DIV << 2);
  localparam logic [AW-1:0] ADDR_PCM_FRAC = AW'(`ACD_IDX_PCM_FRAC << 2);
  localparam logic [AW-1:0] ADDR_PDM_CLKDIV = AW'(`ACD_IDX_PDM_CLKDIV << 2);
  localparam logic [AW-1:0] ADDR_RATE_CLKDIV = AW'(`ACD_IDX_RATE_CLKDIV << 2);
  localparam logic [AW-1:0] ADDR_STATUS = AW'(`ACD_IDX_STATUS << 2);

  acd_bus_state_t st;
  acd_reg_t pcm_clock_divider;
  acd_reg_t pcm_clock_fraction;
  acd_reg_t pdm_clock_divider;
  acd_reg_t rate_converter_clock_divider;
  acd_reg_t status;
  acd_reg_t rd_val;
  logic rd_hit;
  logic wr_go;

  logic pcm_en;
  logic pdm_clock_enable;
  logic rate_converter_clock_enable;
  logic [15:0] pcm_fraction_pattern;
  logic [11:0] pcm_integer_divider;
  logic [7:0] pdm_integer_divider;
  logic [7:0] rate_converter_divider;

  logic [3:0] frac_top;
  logic [4:0] frac_ones;
  logic frac_on;
  logic [3:0] frac_pos;
  logic pcm_extra;
  logic pcm_run;
  logic pcm_wrap;
  logic pdm_run;
  logic src_run;
  logic pcm_clk_i;
  logic pcm_tick_i;
  logic pdm_clk_i;
  logic pdm_tick_i;
  logic src_clk_i;
  logic src_tick_i;

  // ==========================================================
  // Field views
  assign pcm_en = pcm_clock_divider[`ACD_PCM_EN_BIT];
  assign pcm_integer_divider = pcm_clock_divider[`ACD_PCM_DIV_MSB:0];
  assign pcm_fraction_pattern = pcm_clock_fraction;
  assign pdm_clock_enable = pdm_clock_divider[`ACD_PDM_EN_BIT];
  assign pdm_integer_divider = pdm_clock_divider[`ACD_DIV8_MSB:0];
  assign rate_converter_clock_enable = rate_converter_clock_divider[`ACD_SRC_EN_BIT];
  assign rate_converter_divider = rate_converter_clock_divider[`ACD_DIV8_MSB:0];

  // ==========================================================
  // APB slave
  always_comb begin
    rd_hit = 1'b1;
    case (paddr)
      ADDR_PCM_DIV: rd_val = pcm_clock_divider;
      ADDR_PCM_FRAC: rd_val = pcm_clock_fraction;
      ADDR_PDM_CLKDIV: rd_val = pdm_clock_divider;
      ADDR_RATE_CLKDIV: rd_val = rate_converter_clock_divider;
      ADDR_STATUS: rd_val = status;
      default: begin
        rd_val = `ACD_REG_RESET;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data is sampled in the setup cycle, one cycle before it is taken.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ACD_BUS_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      case (st)
        ACD_BUS_IDLE: begin
          if (psel && !penable) begin
            st <= ACD_BUS_ANSWER;
            pready <= 1'b1;
            pslverr <= !rd_hit;
            prdata <= {16'h0000, rd_val};
          end
        end
        ACD_BUS_ANSWER: begin
          st <= ACD_BUS_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          st <= ACD_BUS_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  assign wr_go = psel && penable && pready && pwrite;

  // Divider and enable share one word, so a single write may set both.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcm_clock_divider <= `ACD_REG_RESET;
      pcm_clock_fraction <= `ACD_REG_RESET;
      pdm_clock_divider <= `ACD_REG_RESET;
      rate_converter_clock_divider <= `ACD_REG_RESET;
    end else if (wr_go) begin
      case (paddr)
        ADDR_PCM_DIV: pcm_clock_divider <= pwdata[15:0] & `ACD_PCM_DIV_MASK;
        ADDR_PCM_FRAC: pcm_clock_fraction <= pwdata[15:0];
        ADDR_PDM_CLKDIV: pdm_clock_divider <= pwdata[15:0] & `ACD_PDM_CLKDIV_MASK;
        ADDR_RATE_CLKDIV: rate_converter_clock_divider <= pwdata[15:0] & `ACD_RATE_CLKDIV_MASK;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Fraction pattern decode
  always_comb begin
    frac_top = 4'h0;
    frac_ones = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (pcm_fraction_pattern[i]) begin
        frac_top = 4'(i);
        frac_ones = frac_ones + 5'h01;
      end
    end
  end

  assign frac_on = |pcm_fraction_pattern;
  assign pcm_extra = frac_on && pcm_fraction_pattern[frac_pos];

  // The position restarts at the top whenever the clock is not running, so
  // every enable begins the sequence at the highest set bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frac_pos <= 4'h0;
    end else if (!pcm_run) begin
      frac_pos <= frac_top;
    end else if (pcm_wrap) begin
      if (frac_pos == 4'h0 || frac_pos > frac_top) begin
        frac_pos <= frac_top;
      end else begin
        frac_pos <= frac_pos - 4'h1;
      end
    end
  end

  assign status = {pcm_run, pdm_run, frac_pos,
                   frac_on ? 5'(frac_top) + 5'h01 : 5'h00, frac_ones};

  // ==========================================================
  // Dividers
  acd_divider #(.W(12)) u_pcm (
    .clk(pclk),
    .rst_n(presetn),
    .en(pcm_en),
    .div(pcm_integer_divider),
    .extra(pcm_extra),
    .clk_out(pcm_clk_i),
    .tick(pcm_tick_i),
    .run(pcm_run),
    .wrap(pcm_wrap)
  );

  acd_divider #(.W(8)) u_pdm (
    .clk(pclk),
    .rst_n(presetn),
    .en(pdm_clock_enable),
    .div(pdm_integer_divider),
    .extra(1'b0),
    .clk_out(pdm_clk_i),
    .tick(pdm_tick_i),
    .run(pdm_run),
    .wrap()
  );

  acd_divider #(.W(8)) u_src (
    .clk(pclk),
    .rst_n(presetn),
    .en(rate_converter_clock_enable),
    .div(rate_converter_divider),
    .extra(1'b0),
    .clk_out(src_clk_i),
    .tick(src_tick_i),
    .run(src_run),
    .wrap()
  );

  // ==========================================================
  // Output stage
  // The dividers already register their outputs; these flops keep the
  // three clocks aligned with the master-mode pin enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcm_clk <= 1'b0;
      pcm_tick <= 1'b0;
      pdm_clk <= 1'b0;
      pdm_tick <= 1'b0;
      pdm_clk_oe <= 1'b0;
      pdm_master_select <= 1'b0;
      src_clk <= 1'b0;
      src_tick <= 1'b0;
    end else begin
      pcm_clk <= pcm_clk_i;
      pcm_tick <= pcm_tick_i;
      pdm_clk <= pdm_clk_i;
      pdm_tick <= pdm_tick_i;
      pdm_master_select <= pdm_clock_divider[`ACD_PDM_MASTER_BIT];
      // In slave mode the far side owns the PDM clock pin.
      pdm_clk_oe <= pdm_clock_divider[`ACD_PDM_MASTER_BIT] && pdm_run;
      src_clk <= src_clk_i;
      src_tick <= src_tick_i;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [13:0] pcm_gap;
  logic [13:0] pdm_gap;
  logic pcm_extra_q;
  logic [12:0] pcm_eff;
  logic [8:0] pdm_eff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcm_gap <= 14'h0000;
      pdm_gap <= 14'h0000;
      pcm_extra_q <= 1'b0;
    end else begin
      pcm_gap <= pcm_tick_i ? 14'h0001 : pcm_gap + 14'h0001;
      pdm_gap <= pdm_tick_i ? 14'h0001 : pdm_gap + 14'h0001;
      pcm_extra_q <= pcm_extra;
    end
  end

  assign pcm_eff = (pcm_integer_divider == 12'h000) ? 13'h0001 : {1'b0, pcm_integer_divider};
  assign pdm_eff = (pdm_integer_divider == 8'h00) ? 9'h001 : {1'b0, pdm_integer_divider};

  sequence s_pcm_enable;
    $rose(pcm_en);
  endsequence

  sequence s_pcm_clean_start;
    pcm_tick_i && pcm_clk_i ##1 pcm_clk && pcm_tick;
  endsequence

  a_pcm_clock_gated: assert property (!pcm_en |=> ##1 !pcm_clk && !pcm_tick)
    else $error("PCM clock active while disabled");
  a_pdm_clock_gated: assert property (!pdm_clock_enable |=> ##1 !pdm_clk)
    else $error("PDM clock active while disabled");
  a_src_clock_gated: assert property (!rate_converter_clock_enable |=> ##1 !src_clk)
    else $error("Converter clock active while disabled");
  a_pcm_clean_start: assert property (s_pcm_enable |=> s_pcm_clean_start)
    else $error("PCM clock did not start at period start");
  a_frac_top_bit: assert property (frac_on |-> (pcm_fraction_pattern >> frac_top) == 16'h0001
      && frac_ones == 5'($countones(pcm_fraction_pattern)))
    else $error("Fraction pattern decode wrong");
  a_frac_walk_down: assert property (pcm_wrap && frac_pos != 4'h0 && frac_pos <= frac_top
      && $stable(pcm_fraction_pattern) |=> frac_pos == $past(frac_pos) - 4'h1)
    else $error("Fraction position did not step down");
  a_frac_wraps_top: assert property (pcm_wrap && frac_pos == 4'h0
      |=> frac_pos == $past(frac_top))
    else $error("Fraction sequence did not restart at top bit");
  a_pdm_period_len: assert property (pdm_tick_i && $past(pdm_run) && $stable(pdm_eff)
      |-> pdm_gap == 14'(pdm_eff))
    else $error("PDM period length wrong");
  a_pcm_period_len: assert property (pcm_tick_i && $past(pcm_run) && $stable(pcm_eff)
      |-> pcm_gap == 14'(pcm_eff) + 14'(pcm_extra_q))
    else $error("PCM period length wrong");
  a_pdm_slave_mode: assert property (!pdm_clock_divider[`ACD_PDM_MASTER_BIT]
      |=> !pdm_clk_oe && !pdm_master_select)
    else $error("PDM pin driven in slave mode");
  a_pdm_master_drive: assert property (pdm_clock_divider[`ACD_PDM_MASTER_BIT] && pdm_run
      |=> pdm_clk_oe && pdm_master_select)
    else $error("PDM pin not driven in master mode");

endmodule // acd_top

// [hw/acd_cfg.svh]
`ifndef ACD_CFG_SVH
`define ACD_CFG_SVH

// ==========================================================
// Register indexes; the byte address is four times the index.
`define ACD_IDX_PCM_DIV 32'h50001C40
`define ACD_IDX_PCM_FRAC 32'h50001C42
`define ACD_IDX_PDM_CLKDIV 32'h50001C44
`define ACD_IDX_RATE_CLKDIV 32'h50001C46
`define ACD_IDX_STATUS 32'h50001C48

// ==========================================================
// Field positions.
`define ACD_PCM_EN_BIT 12
`define ACD_PCM_DIV_MSB 11
`define ACD_PDM_MASTER_BIT 9
`define ACD_PDM_EN_BIT 8
`define ACD_SRC_EN_BIT 8
`define ACD_DIV8_MSB 7

// ==========================================================
// Writable bits and reset values.
`define ACD_PCM_DIV_MASK 16'h3FFF
`define ACD_PDM_CLKDIV_MASK 16'h03FF
`define ACD_RATE_CLKDIV_MASK 16'h01FF
`define ACD_REG_RESET 16'h0000

`endif

// [hw/acd_pkg.sv]
package acd_pkg;

  typedef enum logic [0:0] {
    ACD_BUS_IDLE = 1'b0,
    ACD_BUS_ANSWER = 1'b1
  } acd_bus_state_t;

  typedef logic [15:0] acd_reg_t;

endpackage

// [hw/acd_divider.sv]
`timescale 1ns/1ps

// ==========================================================
// Integer divider with an optional extra source cycle per period.
module acd_divider #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic en,
  input wire logic [W-1:0] div,
  input wire logic extra,
  // Generated clock
  output logic clk_out,
  output logic tick,
  output logic run,
  output logic wrap
);

  logic [W:0] cnt;
  logic [W:0] last;
  logic [W:0] half;
  logic [W:0] next_cnt;

  // A divider of zero acts as one, so a period is never shorter than a cycle.
  always_comb begin
    last = {1'b0, (div == '0) ? W'(1) : div} - (W+1)'(1) + (W+1)'(extra);
    half = (last + (W+1)'(2)) >> 1;
    // A divider lowered mid-period ends the period at once instead of counting round.
    wrap = run && (cnt >= last);
    next_cnt = (run && !wrap) ? cnt + (W+1)'(1) : '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run <= 1'b0;
      cnt <= '0;
      clk_out <= 1'b0;
      tick <= 1'b0;
    end else if (!en) begin
      run <= 1'b0;
      cnt <= '0;
      clk_out <= 1'b0;
      tick <= 1'b0;
    end else begin
      run <= 1'b1;
      cnt <= next_cnt;
      clk_out <= (next_cnt < half);
      tick <= (next_cnt == '0);
    end
  end

endmodule // acd_divider

// [verification/acd_clk_sink.sv]
`timescale 1ns/1ps

// ==========================================================
// Clock consumer: measures each period and its high time between ticks.
module acd_clk_sink (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Generated clock
  input wire logic clk_in,
  input wire logic tick,
  // Measurement
  output logic [15:0] period,
  output logic [15:0] high_len,
  output logic seen
);
  logic [15:0] cnt;
  logic [15:0] hcnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      hcnt <= 16'h0000;
      period <= 16'h0000;
      high_len <= 16'h0000;
      seen <= 1'b0;
    end else begin
      seen <= tick;
      if (tick) begin
        period <= cnt;
        high_len <= hcnt;
        cnt <= 16'h0001;
        hcnt <= 16'h0001;
      end else begin
        cnt <= cnt + 16'h0001;
        hcnt <= hcnt + {15'h0000, clk_in};
      end
    end
  end
endmodule // acd_clk_sink

// [verification/audio_clock_dividers_tb.sv]
`timescale 1ns/1ps

module audio_clock_dividers_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic pcm_clk, pcm_tick, pdm_clk, pdm_tick, pdm_clk_oe, pdm_master_select, src_clk, src_tick;
  logic [15:0] per [3];
  logic [15:0] hl [3];
  logic seen [3];
  logic [2:0] clks, ticks;
  int bad_count = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic err;
  logic [15:0] p, h, frac;
  logic [11:0] regs [4] = '{12'h100, 12'h108, 12'h110, 12'h118};
  logic [15:0] masks [4] = '{16'h3FFF, 16'hFFFF, 16'h03FF, 16'h01FF};

  always #5 pclk = ~pclk;

  assign clks = {src_clk, pdm_clk, pcm_clk};
  assign ticks = {src_tick, pdm_tick, pcm_tick};

  acd_top acd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pcm_clk(pcm_clk), .pcm_tick(pcm_tick), .pdm_clk(pdm_clk),
    .pdm_tick(pdm_tick), .pdm_clk_oe(pdm_clk_oe), .pdm_master_select(pdm_master_select),
    .src_clk(src_clk), .src_tick(src_tick));

  for (genvar i = 0; i < 3; i++) begin : g_sink
    acd_clk_sink acd_clk_sink_inst (.pclk(pclk), .presetn(presetn), .clk_in(clks[i]),
      .tick(ticks[i]), .period(per[i]), .high_len(hl[i]), .seen(seen[i]));
  end

  task results();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task check(input string name, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; it waits for pready however long it takes, the watchdog ends a hang.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task next_period(input int i);
    do begin
      @(posedge pclk);
    end while (seen[i] !== 1'b1);
    p = per[i];
    h = hl[i];
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, regs[i], 32'h0);
      check("reset value", rd, 32'h0);
    end
    apb(1'b0, 12'h124, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, regs[i], 32'hFFFFFFFF);
      apb(1'b0, regs[i], 32'h0);
      check("masked readback", rd, {16'h0, masks[i]});
      apb(1'b1, regs[i], 32'h0);
    end
    // Divider and enable go in one write, which software is allowed to do.
    apb(1'b1, 12'h110, 32'h0303);
    next_period(1);
    next_period(1);
    check("pdm period", p, 16'h3);
    check("pdm high", h, 16'h2);
    check("pdm oe master", pdm_clk_oe, 1'b1);
    check("pdm select", pdm_master_select, 1'b1);
    apb(1'b1, 12'h110, 32'h0103);
    repeat (3) @(posedge pclk);
    check("pdm oe slave", pdm_clk_oe, 1'b0);
    check("pdm select slave", pdm_master_select, 1'b0);
    // A zero divider acts as one: the clock stays high and ticks every cycle.
    apb(1'b1, 12'h110, 32'h0100);
    repeat (5) @(posedge pclk);
    next_period(1);
    check("pdm_integer_divider zero period", p, 16'h1);
    check("pdm_integer_divider zero high", h, 16'h1);
    apb(1'b1, 12'h118, 32'h0105);
    next_period(2);
    next_period(2);
    check("src period", p, 16'h5);
    check("src high", h, 16'h3);
    apb(1'b1, 12'h118, 32'h0005);
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      check("src disabled", {src_clk, src_tick}, 2'b00);
    end
    frac = 16'h0110;
    apb(1'b1, 12'h108, {16'h0, frac});
    // The divider is written ahead of its enable.
    apb(1'b1, 12'h100, 32'h0004);
    apb(1'b1, 12'h100, 32'h1004);
    next_period(0);
    for (int pos = 8; pos >= 0; pos--) begin
      next_period(0);
      check("pcm period", p, 16'h4 + frac[pos]);
    end
    next_period(0);
    check("pcm period wrap", p, 16'h5);
    apb(1'b0, 12'h120, 32'h0);
    check("fraction numerator", rd[4:0], 5'h02);
    check("fraction denominator", rd[9:5], 5'h09);
    check("pcm running", rd[15], 1'b1);
    check("pdm running", rd[14], 1'b1);
    apb(1'b1, 12'h100, 32'h0004);
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 12; i++) begin
      @(posedge pclk);
      check("pcm disabled", {pcm_clk, pcm_tick}, 2'b00);
    end
    results();
  end

  // The whole sequence needs well under 2000 cycles.
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule // audio_clock_dividers_tb
